//--- verilog/sxsa_pkg.sv
// package: opcodes, widths and reset values for the byte alu datapath
package sxsa_pkg;
    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 7;
    localparam int          NIB_LO_MSB   = 3;
    localparam int          NIB_HI_LSB   = 4;
    localparam logic        DEST_WORK    = 1'b0;
    localparam logic        DEST_FILE    = 1'b1;
    localparam logic [7:0]  WORK_RST     = 8'h00;
    localparam logic        FLAG_RST     = 1'b0;
    localparam logic [6:0]  ADDR_RST     = 7'h00;

    typedef enum logic [1:0] {
        OP_SUBTRACT_WORK_FROM_FILE,
        OP_XOR_LITERAL_INTO_WORK,
        OP_EXCHANGE_FILE_NIBBLES,
        OP_XOR_WORK_WITH_FILE
    } sxsa_op_e;
endpackage : sxsa_pkg

//--- verilog/sxsa_nib_sub.sv
// module: W-bit subtractor (nibble-wide by default) giving difference and no-borrow
`timescale 1ns/1ps
module sxsa_nib_sub #(
    parameter int W = 4
) (
    // operands
    input  wire logic [W-1:0] i_min,
    input  wire logic [W-1:0] i_sub,
    // results
    output logic      [W-1:0] o_diff,
    output logic              o_no_borrow
);
    logic [W:0] full;

    always_comb
    begin
        // extended add of the inverted subtrahend: carry out is no-borrow
        full        = {1'b0, i_min} + {1'b0, ~i_sub} + {{W{1'b0}}, 1'b1};
        o_diff      = full[W-1:0];
        o_no_borrow = full[W];
    end
endmodule : sxsa_nib_sub

//--- verilog/sxsa_alu.sv
// module: execution datapath for subtract, xor and nibble exchange
//
// Operation
// - subtract_work_from_file gives the addressed byte (address 0..127) minus work, two's complement.
// - for the subtraction, dest 0 writes work and dest 1 writes the addressed byte.
// - after subtraction carry is 0 when work exceeds the byte, else 1, digit carry likewise on bits 3:0, and zero updates.
// - xor_literal_into_work xors work with the 8-bit literal, always writes work, and only touches zero.
// - exchange_file_nibbles swaps bits 3:0 and 7:4 of the byte and leaves all flags alone.
// - for the nibble exchange, dest 0 writes work and dest 1 writes the addressed byte.
// - xor_work_with_file xors work with the byte, updates only zero, and keeps carry and digit carry.
// - for the file xor, dest 0 writes work and dest 1 writes the addressed byte.
`timescale 1ns/1ps
module sxsa_alu #(
    parameter int DW = sxsa_pkg::DATA_W,
    parameter int AW = sxsa_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_nrst,
    // instruction from the decoder
    input  wire logic              i_exec,
    input  wire sxsa_pkg::sxsa_op_e i_op,
    input  wire logic              i_dest,
    input  wire logic [AW-1:0]     i_addr,
    input  wire logic [DW-1:0]     i_literal,
    // operand read from data memory
    input  wire logic [DW-1:0]     i_file_data,
    // working register and status
    output logic      [DW-1:0]     o_work,
    output logic                   o_carry,
    output logic                   o_digit_carry_flag,
    output logic                   o_zero,
    // file write-back
    output logic                   o_file_we,
    output logic      [AW-1:0]     o_file_addr,
    output logic      [DW-1:0]     o_file_wdata
);
    typedef struct packed {
        logic [DW-1:0] work;
        logic          carry;
        logic          dc;
        logic          zero;
        logic          we;
        logic [AW-1:0] waddr;
        logic [DW-1:0] wdata;
    } sxsa_state_s;

    sxsa_state_s st_r;
    sxsa_state_s st_nxt;

    logic [DW-1:0] diff;
    logic          no_borrow;
    logic          lo_no_borrow;
    logic [DW-1:0] result;
    logic          to_file;
    logic          upd_cdc;
    logic          upd_z;

    // full byte and low nibble share one module so both borrows stay consistent
    sxsa_nib_sub #(.W(DW)) u_sub_byte (
        .i_min       (i_file_data),
        .i_sub       (st_r.work),
        .o_diff      (diff),
        .o_no_borrow (no_borrow)
    );

    // low nibble: only its borrow is wanted, it becomes the digit carry
    sxsa_nib_sub #(.W(4)) u_sub_low (
        .i_min       (i_file_data[sxsa_pkg::NIB_LO_MSB:0]),
        .i_sub       (st_r.work[sxsa_pkg::NIB_LO_MSB:0]),
        .o_diff      (),
        .o_no_borrow (lo_no_borrow)
    );

    always_comb
    begin
        st_nxt  = st_r;
        result  = '0;
        to_file = 1'b0;
        upd_cdc = 1'b0;
        upd_z   = 1'b0;
        st_nxt.we = 1'b0;
        case (i_op)
            sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE:
            begin
                result  = diff;
                to_file = (i_dest == sxsa_pkg::DEST_FILE);
                upd_cdc = 1'b1;
                upd_z   = 1'b1;
            end
            sxsa_pkg::OP_XOR_LITERAL_INTO_WORK:
            begin
                result  = st_r.work ^ i_literal;
                to_file = 1'b0;
                upd_z   = 1'b1;
            end
            sxsa_pkg::OP_EXCHANGE_FILE_NIBBLES:
            begin
                result  = {i_file_data[sxsa_pkg::NIB_LO_MSB:0],
                           i_file_data[DW-1:sxsa_pkg::NIB_HI_LSB]};
                to_file = (i_dest == sxsa_pkg::DEST_FILE);
            end
            sxsa_pkg::OP_XOR_WORK_WITH_FILE:
            begin
                result  = st_r.work ^ i_file_data;
                to_file = (i_dest == sxsa_pkg::DEST_FILE);
                upd_z   = 1'b1;
            end
            default:
            begin
                result = st_r.work;
            end
        endcase
        if (i_exec)
        begin
            if (to_file)
            begin
                st_nxt.we    = 1'b1;
                st_nxt.waddr = i_addr;
                st_nxt.wdata = result;
            end
            else
            begin
                st_nxt.work = result;
            end
            if (upd_cdc)
            begin
                st_nxt.carry = no_borrow;
                st_nxt.dc    = lo_no_borrow;
            end
            if (upd_z)
            begin
                st_nxt.zero = (result == '0);
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            st_r.work  <= sxsa_pkg::WORK_RST;
            st_r.carry <= sxsa_pkg::FLAG_RST;
            st_r.dc    <= sxsa_pkg::FLAG_RST;
            st_r.zero  <= sxsa_pkg::FLAG_RST;
            st_r.we    <= 1'b0;
            st_r.waddr <= sxsa_pkg::ADDR_RST;
            st_r.wdata <= sxsa_pkg::WORK_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_work             = st_r.work;
    assign o_carry            = st_r.carry;
    assign o_digit_carry_flag = st_r.dc;
    assign o_zero             = st_r.zero;
    assign o_file_we          = st_r.we;
    assign o_file_addr        = st_r.waddr;
    assign o_file_wdata       = st_r.wdata;

    chk_sub_value: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE && !i_dest)
        |=> (o_work == DW'($past(i_file_data) - $past(o_work))))
        else $error("subtract result wrong");

    chk_sub_dest: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE && i_dest)
        |=> (o_file_we && o_file_addr == $past(i_addr) && $stable(o_work)))
        else $error("subtract to file not routed");

    chk_sub_carry: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE)
        |=> (o_carry == ($past(o_work) <= $past(i_file_data))
             && o_digit_carry_flag == ($past(o_work[3:0]) <= $past(i_file_data[3:0]))))
        else $error("subtract carry flags wrong");

    chk_xorl_work: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_XOR_LITERAL_INTO_WORK)
        |=> (!o_file_we && o_work == ($past(o_work) ^ $past(i_literal)) && $stable(o_carry)))
        else $error("literal xor wrong");

    chk_swap_flags: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_EXCHANGE_FILE_NIBBLES)
        |=> ($stable(o_zero) && $stable(o_carry) && $stable(o_digit_carry_flag)))
        else $error("nibble exchange touched flags");

    chk_swap_dest: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_EXCHANGE_FILE_NIBBLES && i_dest)
        |=> (o_file_we && o_file_wdata == {$past(i_file_data[3:0]), $past(i_file_data[7:4])}))
        else $error("nibble exchange to file wrong");

    chk_xorf_keep: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_XOR_WORK_WITH_FILE)
        |=> ($stable(o_carry) && $stable(o_digit_carry_flag)))
        else $error("file xor changed carry");

    chk_xorf_dest: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_XOR_WORK_WITH_FILE && !i_dest)
        |=> (!o_file_we && o_work == ($past(o_work) ^ $past(i_file_data))))
        else $error("file xor to work wrong");

    chk_zero_flag: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_XOR_LITERAL_INTO_WORK)
        |=> (o_zero == (o_work == '0)))
        else $error("zero flag wrong");

    // a file-destination issue and the write pulse it must raise one cycle later
    sequence s_file_dest_issue;
        i_exec && i_dest && (i_op != sxsa_pkg::OP_XOR_LITERAL_INTO_WORK);
    endsequence

    sequence s_file_write_pulse;
        o_file_we && (o_file_addr == $past(i_addr)) && $stable(o_work);
    endsequence

    chk_file_pulse: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_file_dest_issue |=> s_file_write_pulse)
        else $error("file destination not written");

    chk_idle_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (!i_exec)
        |=> (!o_file_we && $stable(o_work) && $stable(o_zero) && $stable(o_carry)))
        else $error("idle cycle changed state");

    chk_sub_wdata: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE && i_dest)
        |=> (o_file_wdata == DW'($past(i_file_data) - $past(o_work))))
        else $error("subtract write data wrong");

    chk_swap_work: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_EXCHANGE_FILE_NIBBLES && !i_dest)
        |=> (!o_file_we && o_work == {$past(i_file_data[3:0]), $past(i_file_data[7:4])}))
        else $error("nibble exchange to work wrong");

    chk_xorf_file: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && i_op == sxsa_pkg::OP_XOR_WORK_WITH_FILE && i_dest)
        |=> (o_file_we && o_file_wdata == ($past(o_work) ^ $past(i_file_data))))
        else $error("file xor to file wrong");

    // subtract and the file xor both give zero exactly when the byte equals work
    chk_zero_equal: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exec && (i_op == sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE
                    || i_op == sxsa_pkg::OP_XOR_WORK_WITH_FILE))
        |=> (o_zero == ($past(i_file_data) == $past(o_work))))
        else $error("zero flag after file operation wrong");
endmodule : sxsa_alu

//--- verification/sxsa_file_model.sv
// data memory file model: feeds the alu operand and takes its write-back
`timescale 1ns/1ps
module sxsa_file_model (
    // clock
    input  wire logic       i_core_clk,
    // operand read
    input  wire logic [6:0] i_addr,
    output logic      [7:0] o_rdata,
    // write-back
    input  wire logic       i_we,
    input  wire logic [6:0] i_waddr,
    input  wire logic [7:0] i_wdata
);
    logic [7:0] mem_r [128];

    initial
    begin
        for (int a = 0; a < 128; a++)
            mem_r[a] = 8'(a * 37) ^ 8'h5a;
    end

    // read is combinational because the alu samples the byte in its execute cycle
    assign o_rdata = mem_r[i_addr];

    always @(posedge i_core_clk)
    begin
        if (i_we)
            mem_r[i_waddr] <= i_wdata;
    end
endmodule : sxsa_file_model

//--- verification/sxsa_alu_tb.sv
// self-checking testbench for the byte alu datapath
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module sxsa_alu_tb;
    logic               i_core_clk, i_nrst, i_exec, i_dest, o_carry, o_digit_carry_flag;
    logic               o_zero, o_file_we, ec, edc, ez, pw;
    sxsa_pkg::sxsa_op_e i_op;
    logic [6:0]         i_addr, o_file_addr, pa;
    logic [7:0]         i_literal, i_file_data, o_work, o_file_wdata, ew, fb, res, pv;
    int                 num_errors = 0;
    int                 total_checks = 0;

    sxsa_alu i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_exec(i_exec), .i_op(i_op),
        .i_dest(i_dest), .i_addr(i_addr), .i_literal(i_literal), .i_file_data(i_file_data),
        .o_work(o_work), .o_carry(o_carry), .o_digit_carry_flag(o_digit_carry_flag),
        .o_zero(o_zero), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
        .o_file_wdata(o_file_wdata));
    sxsa_file_model i_mem (.i_core_clk(i_core_clk), .i_addr(i_addr), .o_rdata(i_file_data),
        .i_we(o_file_we), .i_waddr(o_file_addr), .i_wdata(o_file_wdata));

    initial
    begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    // a write-back lands in the file model one edge after its pulse, so it is checked then
    task automatic edge_step();
        @(posedge i_core_clk);
        #1;
        if (pw)
        begin
            `CHK(i_mem.mem_r[pa], pv)
        end
        pw = 1'b0;
    endtask : edge_step

    task automatic check_state();
        `CHK({o_work, o_carry, o_digit_carry_flag, o_zero}, {ew, ec, edc, ez})
    endtask : check_state

    task automatic run(input sxsa_pkg::sxsa_op_e op, input logic d, input logic [6:0] a,
                       input logic [7:0] lit);
        logic wr;
        fb = i_mem.mem_r[a];
        wr = d && (op != sxsa_pkg::OP_XOR_LITERAL_INTO_WORK);
        case (op)
            sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE:
            begin
                res = fb - ew;
                ec  = (ew <= fb);
                edc = (ew[3:0] <= fb[3:0]);
            end
            sxsa_pkg::OP_XOR_LITERAL_INTO_WORK: res = ew ^ lit;
            sxsa_pkg::OP_EXCHANGE_FILE_NIBBLES: res = {fb[3:0], fb[7:4]};
            default: res = ew ^ fb;
        endcase
        if (op != sxsa_pkg::OP_EXCHANGE_FILE_NIBBLES)
            ez = (res == 8'h00);
        if (!wr)
            ew = res;
        i_exec    = 1'b1;
        i_op      = op;
        i_dest    = d;
        i_addr    = a;
        i_literal = lit;
        edge_step();
        `CHK(o_file_we, wr)
        if (wr)
        begin
            `CHK({o_file_addr, o_file_wdata}, {a, res})
            pw = 1'b1;
            pa = a;
            pv = res;
        end
        check_state();
    endtask : run

    // back-to-back execution leaves i_exec high, so idle cycles are inserted explicitly
    task automatic idle();
        i_exec = 1'b0;
        edge_step();
        `CHK(o_file_we, 1'b0)
        check_state();
    endtask : idle

    task automatic set_w(input logic [7:0] v);
        run(sxsa_pkg::OP_XOR_LITERAL_INTO_WORK, 1'b1, 7'h00, v ^ ew);
    endtask : set_w

    task automatic do_reset();
        i_nrst = 1'b0;
        i_exec = 1'b0;
        repeat (2) edge_step();
        {ew, ec, edc, ez} = '0;
        check_state();
        `CHK({o_file_we, o_file_addr, o_file_wdata}, 16'h0000)
        i_nrst = 1'b1;
    endtask : do_reset

    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    initial
    begin
        i_op      = sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE;
        i_dest    = 1'b0;
        i_addr    = 7'h00;
        i_literal = 8'h00;
        pw        = 1'b0;
        do_reset();
        // equal operands: zero result with both carries set
        set_w(i_mem.mem_r[5]);
        run(sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE, 1'b1, 7'h05, 8'h00);
        // work one above the byte: borrow on both nibble and byte
        set_w(8'h01);
        run(sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE, 1'b0, 7'h05, 8'h00);
        for (int i = 0; i < 32; i++)
        begin
            set_w(8'(i * 29));
            run(sxsa_pkg::sxsa_op_e'(i % 4), i[2], 7'(i * 41), 8'(i * 53));
            if (i % 3 == 0)
                idle();
        end
        run(sxsa_pkg::OP_EXCHANGE_FILE_NIBBLES, 1'b1, 7'h7f, 8'h00);
        run(sxsa_pkg::OP_XOR_WORK_WITH_FILE, 1'b0, 7'h7f, 8'h00);
        do_reset();
        run(sxsa_pkg::OP_SUBTRACT_WORK_FROM_FILE, 1'b0, 7'h7f, 8'h00);
        finish_test();
    end
endmodule : sxsa_alu_tb
